// ===== rtl/dmaz_regs.vh
`ifndef DMAZ_REGS_VH
`define DMAZ_REGS_VH
// Register indices (printed offsets); byte address is four times the index
`define DMAZ_IDX_CTRL     16'h04CC
`define DMAZ_IDX_IRQ      16'h04CE
`define DMAZ_IDX_SRC      16'h04D0
`define DMAZ_IDX_DST      16'h04D2
`define DMAZ_IDX_CNT      16'h04D4
`define DMAZ_IDX_LOW      16'h04C8
`define DMAZ_IDX_HIGH     16'h04CA
`define DMAZ_RESET_VAL    16'h0000
// Control fields
`define DMAZ_CTL_ON       0
`define DMAZ_CTL_SIZE     1
`define DMAZ_CTL_MODE_LO  2
`define DMAZ_CTL_MODE_HI  3
`define DMAZ_CTL_DST_LO   4
`define DMAZ_CTL_DST_HI   5
`define DMAZ_CTL_SRC_LO   6
`define DMAZ_CTL_SRC_HI   7
`define DMAZ_CTL_SWREQ    8
`define DMAZ_CTL_RELOAD   9
`define DMAZ_CTL_DUMMY    10
`define DMAZ_CTL_MASK     16'h07FF
// Flag fields
`define DMAZ_IRQ_MIDPOINT_IRQ_ENABLE   0
`define DMAZ_IRQ_OVRUN    3
`define DMAZ_IRQ_HALF     4
`define DMAZ_IRQ_DONE     5
`define DMAZ_IRQ_LOW      6
`define DMAZ_IRQ_HIGH     7
`define DMAZ_IRQ_SEL_LO   8
`define DMAZ_IRQ_SEL_HI   14
`define DMAZ_IRQ_PEND     15
`define DMAZ_IRQ_WMASK    16'h7FF9
// Transfer modes
`define DMAZ_MODE_ONESHOT 2'b00
`define DMAZ_MODE_REP_ONE 2'b01
`define DMAZ_MODE_CONT    2'b10
`define DMAZ_MODE_REP_CON 2'b11
// Step modes
`define DMAZ_STEP_INC     2'b01
`define DMAZ_STEP_DEC     2'b10
// Address map
`define DMAZ_SFR_TOP      16'h07FF
`define DMAZ_RAM_TOP      16'h27FF
`endif

// ===== rtl/dmaz_step.v
`timescale 1ns/1ps
// Pointer stepper: one byte or one word up or down
module dmaz_step (
	// Operands
	input  wire [15:0] ptr,
	input  wire [1:0]  mode,
	input  wire        byte_size,
	// Result
	output reg  [15:0] next_ptr
);
	wire [15:0] amount;
	assign amount = byte_size ? 16'h0001 : 16'h0002;
	always @* begin
		case (mode)
			2'b01:   next_ptr = ptr + amount;
			2'b10:   next_ptr = ptr - amount;
			default: next_ptr = ptr;
		endcase
	end
endmodule // dmaz_step

// ===== rtl/dmaz_channel.v
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "dmaz_regs.vh"
// Notes on behaviour
// - Mode field: 11 rep-cont, 10 cont, 01 rep-oneshot, 00 oneshot
// - Size bit 1 moves bytes, 0 words
// - Triggers served only while channel_on set
// - Software-written flags raise no interrupt
// - Limits checked at access time, not beforehand
// - Pending flag set until buffer written out
// - Seven-bit field selects hardware trigger source
// - Upper flag: above upper limit or RAM top
// - Lower flag: below lower limit, above 07FFh
// - Complete flag set when session completes
// - Midpoint flag at counter halfway point
// - Overrun flag on trigger during busy transfer
// - Midpoint irq only when midpoint_irq_enable set
// - Source pointer, 16-bit read/write, resets zero
// - Destination pointer, 16-bit read/write, resets zero
// - Transfer counter, 16-bit read/write, resets zero
// - Pointers step by byte or word per mode
// - Software request clears when transfer completes; in continuous modes only when session completes
// - Repeated modes always reload the counter
module dmaz_channel #(
	parameter TRIG_COUNT = 128
) (
	// Clock and reset
	input  wire                  core_clk,
	input  wire                  rst,
	// Register port
	input  wire [15:0]           reg_addr,
	input  wire [15:0]           reg_wdata,
	input  wire                  reg_wr,
	input  wire                  reg_rd,
	output reg  [15:0]           reg_rdata_q,
	// Hardware triggers from pins
	input  wire [TRIG_COUNT-1:0] trig_in,
	// Data bus master
	output reg  [15:0]           bus_addr_q,
	output reg  [15:0]           bus_wdata_q,
	output reg                   bus_wr_q,
	output reg                   bus_rd_q,
	output reg                   bus_byte_q,
	input  wire [15:0]           bus_rdata,
	// Channel interrupt request
	output reg                   irq_q
);
	localparam ST_IDLE  = 4'b0001;
	localparam ST_READ  = 4'b0010;
	localparam ST_WRITE = 4'b0100;
	localparam ST_DUMMY = 4'b1000;

	reg  [15:0] ctrl_q;
	reg  [15:0] flags_q;
	reg  [15:0] src_q;
	reg  [15:0] dst_q;
	reg  [15:0] cnt_q;
	reg  [15:0] low_q;
	reg  [15:0] high_q;
	reg  [15:0] src_save_q;
	reg  [15:0] dst_save_q;
	reg  [15:0] cnt_save_q;
	reg  [15:0] half_q;
	reg  [15:0] buf_q;
	reg  [3:0]  state_q;
	reg         active_q;
	reg  [TRIG_COUNT-1:0] trig_s1_q;
	reg  [TRIG_COUNT-1:0] trig_s2_q;
	reg  [TRIG_COUNT-1:0] trig_s3_q;

	wire        chan_on    = ctrl_q[`DMAZ_CTL_ON];
	wire        byte_size  = ctrl_q[`DMAZ_CTL_SIZE];
	wire [1:0]  mode       = ctrl_q[`DMAZ_CTL_MODE_HI:`DMAZ_CTL_MODE_LO];
	wire [1:0]  src_mode   = ctrl_q[`DMAZ_CTL_SRC_HI:`DMAZ_CTL_SRC_LO];
	wire [1:0]  dst_mode   = ctrl_q[`DMAZ_CTL_DST_HI:`DMAZ_CTL_DST_LO];
	wire        sw_req     = ctrl_q[`DMAZ_CTL_SWREQ];
	wire        dummy_mode = ctrl_q[`DMAZ_CTL_DUMMY];
	wire [6:0]  trig_sel   = flags_q[`DMAZ_IRQ_SEL_HI:`DMAZ_IRQ_SEL_LO];
	wire        repeated   = mode[0];
	wire        continuous = mode[1];

	// Rising edge of the chosen synchronised trigger
	wire hw_edge = trig_s2_q[trig_sel] & ~trig_s3_q[trig_sel];
	wire busy    = (state_q != ST_IDLE);
	wire start   = chan_on & (state_q == ST_IDLE) & (hw_edge | sw_req);

	// Address checks on the access being made
	wire [15:0] acc_addr = (state_q == ST_READ) ? src_q :
		(state_q == ST_WRITE) ? dst_q : src_q;
	wire acc_now  = (state_q != ST_IDLE);
	wire hi_viol  = acc_now & ((acc_addr > high_q) | (acc_addr > `DMAZ_RAM_TOP));
	wire lo_viol  = acc_now & (acc_addr < low_q) & (acc_addr > `DMAZ_SFR_TOP);

	wire [15:0] src_next;
	wire [15:0] dst_next;
	dmaz_step u_src_step (
		.ptr       (src_q),
		.mode      (src_mode),
		.byte_size (byte_size),
		.next_ptr  (src_next)
	);
	dmaz_step u_dst_step (
		.ptr       (dst_q),
		.mode      ((dst_mode == 2'b11) ? 2'b00 : dst_mode),
		.byte_size (byte_size),
		.next_ptr  (dst_next)
	);

	wire wr_ctrl  = reg_wr & (reg_addr == `DMAZ_IDX_CTRL);
	wire wr_flags = reg_wr & (reg_addr == `DMAZ_IDX_IRQ);
	wire wr_src   = reg_wr & (reg_addr == `DMAZ_IDX_SRC);
	wire wr_dst   = reg_wr & (reg_addr == `DMAZ_IDX_DST);
	wire wr_cnt   = reg_wr & (reg_addr == `DMAZ_IDX_CNT);
	// Writable flag bits only; pending bit stays hardware owned
	wire [15:0] flags_wdata = reg_wdata & `DMAZ_IRQ_WMASK;

	// Transfer finishes on the last bus cycle of its sequence
	wire xfer_done = ((state_q == ST_WRITE) & ~dummy_mode) | (state_q == ST_DUMMY);
	wire [15:0] cnt_dec = cnt_q - 16'h0001;
	wire last_xfer = xfer_done & (cnt_dec == 16'h0000);
	wire half_hit  = xfer_done & (cnt_dec == half_q) & (cnt_dec != 16'h0000);
	wire ovr_hit   = busy & hw_edge & chan_on;

	genvar g;
	generate
		for (g = 0; g < TRIG_COUNT; g = g + 1) begin : g_sync
			always @(posedge core_clk) begin
				if (rst) begin
					trig_s1_q[g] <= 1'b0;
					trig_s2_q[g] <= 1'b0;
					trig_s3_q[g] <= 1'b0;
				end else begin
					trig_s1_q[g] <= trig_in[g];
					trig_s2_q[g] <= trig_s1_q[g];
					trig_s3_q[g] <= trig_s2_q[g];
				end
			end
		end
	endgenerate

	// Sequencer and bus master
	always @(posedge core_clk) begin
		if (rst) begin
			state_q     <= ST_IDLE;
			bus_addr_q  <= 16'h0000;
			bus_wdata_q <= 16'h0000;
			bus_wr_q    <= 1'b0;
			bus_rd_q    <= 1'b0;
			bus_byte_q  <= 1'b0;
			buf_q       <= 16'h0000;
		end else begin
			bus_wr_q   <= 1'b0;
			bus_rd_q   <= 1'b0;
			bus_byte_q <= byte_size;
			case (state_q)
				ST_IDLE: begin
					if (start & (cnt_q != 16'h0000)) begin
						state_q    <= ST_READ;
						bus_addr_q <= src_q;
						bus_rd_q   <= 1'b1;
					end
				end
				ST_READ: begin
					buf_q       <= byte_size ? {8'h00, bus_rdata[7:0]} : bus_rdata;
					bus_wdata_q <= byte_size ? {8'h00, bus_rdata[7:0]} : bus_rdata;
					bus_addr_q  <= dst_q;
					bus_wr_q    <= 1'b1;
					state_q     <= ST_WRITE;
				end
				ST_WRITE: begin
					if (dummy_mode) begin
						bus_addr_q <= src_q;
						bus_wr_q   <= 1'b1;
						state_q    <= ST_DUMMY;
					end else if (continuous & ~last_xfer & chan_on) begin
						bus_addr_q <= src_next;
						bus_rd_q   <= 1'b1;
						state_q    <= ST_READ;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				ST_DUMMY: begin
					if (continuous & ~last_xfer & chan_on) begin
						bus_addr_q <= src_next;
						bus_rd_q   <= 1'b1;
						state_q    <= ST_READ;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Pointers, counter and saved session values
	always @(posedge core_clk) begin
		if (rst) begin
			src_q      <= `DMAZ_RESET_VAL;
			dst_q      <= `DMAZ_RESET_VAL;
			cnt_q      <= `DMAZ_RESET_VAL;
			src_save_q <= 16'h0000;
			dst_save_q <= 16'h0000;
			cnt_save_q <= 16'h0000;
			half_q     <= 16'h0000;
			active_q   <= 1'b0;
			low_q      <= 16'h0000;
			high_q     <= 16'hFFFF;
		end else begin
			if (reg_wr & (reg_addr == `DMAZ_IDX_LOW))
				low_q <= reg_wdata;
			if (reg_wr & (reg_addr == `DMAZ_IDX_HIGH))
				high_q <= reg_wdata;
			if (wr_src) begin
				src_q      <= reg_wdata;
				src_save_q <= reg_wdata;
			end else if (xfer_done) begin
				src_q <= src_next;
			end
			if (wr_dst) begin
				dst_q      <= reg_wdata;
				dst_save_q <= reg_wdata;
			end else if (xfer_done) begin
				dst_q <= dst_next;
			end
			if (wr_cnt) begin
				cnt_q      <= reg_wdata;
				cnt_save_q <= reg_wdata;
				half_q     <= {1'b0, reg_wdata[15:1]};
				active_q   <= 1'b1;
			end else if (last_xfer) begin
				active_q <= 1'b0;
				if (repeated | ctrl_q[`DMAZ_CTL_RELOAD]) begin
					cnt_q <= cnt_save_q;
					src_q <= src_save_q;
					dst_q <= dst_save_q;
				end else begin
					cnt_q <= 16'h0000;
				end
			end else if (xfer_done) begin
				cnt_q <= cnt_dec;
			end
		end
	end

	// Control register
	always @(posedge core_clk) begin
		if (rst) begin
			ctrl_q <= 16'h0000;
		end else if (wr_ctrl) begin
			ctrl_q <= reg_wdata & `DMAZ_CTL_MASK;
		end else begin
			if (xfer_done & ~(continuous & ~last_xfer))
				ctrl_q[`DMAZ_CTL_SWREQ] <= 1'b0;
			if (last_xfer & ~repeated)
				ctrl_q[`DMAZ_CTL_ON] <= 1'b0;
		end
	end

	// Flags: hardware set wins over a software write in the same cycle
	always @(posedge core_clk) begin
		if (rst) begin
			flags_q <= 16'h0000;
			irq_q   <= 1'b0;
		end else begin
			if (wr_flags)
				flags_q[14:0] <= flags_wdata[14:0];
			if (wr_cnt)
				flags_q[`DMAZ_IRQ_DONE] <= 1'b0;
			if (hi_viol)
				flags_q[`DMAZ_IRQ_HIGH] <= 1'b1;
			if (lo_viol)
				flags_q[`DMAZ_IRQ_LOW] <= 1'b1;
			if (last_xfer)
				flags_q[`DMAZ_IRQ_DONE] <= 1'b1;
			if (half_hit)
				flags_q[`DMAZ_IRQ_HALF] <= 1'b1;
			if (ovr_hit)
				flags_q[`DMAZ_IRQ_OVRUN] <= 1'b1;
			// Pending while buffered data awaits its final write
			flags_q[`DMAZ_IRQ_PEND] <= (state_q == ST_READ) |
				((state_q == ST_WRITE) & dummy_mode);
			// Pulse only from hardware events, never from a write
			irq_q <= last_xfer | hi_viol | lo_viol | ovr_hit |
				(half_hit & flags_q[`DMAZ_IRQ_MIDPOINT_IRQ_ENABLE]);
		end
	end

	// Register read port
	always @(posedge core_clk) begin
		if (rst) begin
			reg_rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`DMAZ_IDX_CTRL: reg_rdata_q <= ctrl_q;
				`DMAZ_IDX_IRQ:  reg_rdata_q <= flags_q;
				`DMAZ_IDX_SRC:  reg_rdata_q <= src_q;
				`DMAZ_IDX_DST:  reg_rdata_q <= dst_q;
				`DMAZ_IDX_CNT:  reg_rdata_q <= cnt_q;
				`DMAZ_IDX_LOW:  reg_rdata_q <= low_q;
				`DMAZ_IDX_HIGH: reg_rdata_q <= high_q;
				default:        reg_rdata_q <= 16'h0000;
			endcase
		end else begin
			reg_rdata_q <= 16'h0000;
		end
	end
endmodule // dmaz_channel

// ===== bench/dmaz_checker.sv
`timescale 1ns/1ps
`include "dmaz_regs.vh"
module dmaz_checker #(
	parameter TRIG_COUNT = 128
) (
	// Clock and reset
	input wire                  core_clk,
	input wire                  rst,
	// Register port
	input wire [15:0]           reg_addr,
	input wire [15:0]           reg_wdata,
	input wire                  reg_wr,
	input wire                  reg_rd,
	input wire [15:0]           reg_rdata_q,
	// Triggers
	input wire [TRIG_COUNT-1:0] trig_in,
	// Data bus
	input wire [15:0]           bus_addr_q,
	input wire [15:0]           bus_wdata_q,
	input wire                  bus_wr_q,
	input wire                  bus_rd_q,
	input wire                  bus_byte_q,
	input wire [15:0]           bus_rdata,
	// Interrupt
	input wire                  irq_q
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
		else $error("read data not idle");
	AST_WR_AFTER_RD: assert property (bus_rd_q |=> bus_wr_q && !bus_rd_q)
		else $error("read not followed by write");
	AST_WR_DATA: assert property (bus_rd_q ##1 bus_wr_q |->
		bus_wdata_q == (bus_byte_q ? {8'h00, bus_rdata[7:0]} : bus_rdata))
		else $error("write data mismatch");
	AST_DUMMY_SRC: assert property (bus_rd_q ##1 bus_wr_q ##1 bus_wr_q |->
		bus_addr_q == $past(bus_addr_q, 2))
		else $error("dummy write not to source");
	AST_IRQ_PULSE: assert property (irq_q && !bus_rd_q && !bus_wr_q |=> !irq_q)
		else $error("irq continued while channel idle");
	AST_IRQ_CAUSE: assert property (irq_q |->
		$past(bus_rd_q) || $past(bus_wr_q))
		else $error("irq without bus access");
	AST_RESET_QUIET: assert property ($past(rst) |-> !bus_rd_q && !bus_wr_q && !irq_q)
		else $error("bus active after reset");
	AST_OFF_QUIET: assert property (reg_wr && reg_addr == `DMAZ_IDX_CTRL && !reg_wdata[0]
		|=> ##1 !bus_rd_q [*8])
		else $error("read while channel off");
	COV_DUMMY: cover property (bus_wr_q ##1 bus_wr_q);
	COV_IRQ: cover property (irq_q);
	COV_BYTE: cover property (bus_wr_q && bus_byte_q);
endmodule // dmaz_checker

bind dmaz_channel dmaz_checker #(.TRIG_COUNT(TRIG_COUNT)) u_dmaz_checker (.*);

// ===== bench/dmaz_mem.sv
`timescale 1ns/1ps
module dmaz_mem (
	// Clock
	input  wire        core_clk,
	// Data bus
	input  wire [15:0] bus_addr_q,
	input  wire        bus_rd_q,
	output wire [15:0] bus_rdata
);
	logic [15:0] addr_q = 16'h0000;
	logic [15:0] last_q = 16'h0000;
	logic        rd_q = 1'b0;
	function automatic [15:0] mval(input [15:0] a);
		mval = {a[7:0], ~a[15:8]};
	endfunction
	always @(posedge core_clk) begin
		rd_q <= bus_rd_q;
		addr_q <= bus_addr_q;
		last_q <= bus_rdata;
	end
	// Data valid in read cycle and the one after; else inverted so stale data never passes
	assign bus_rdata = bus_rd_q ? mval(bus_addr_q) : (rd_q ? mval(addr_q) : ~last_q);
endmodule // dmaz_mem

// ===== bench/dma_channel_zero_core_test.sv
`timescale 1ns/1ps
`include "dmaz_regs.vh"
module dma_channel_zero_core_test;
	logic         core_clk = 0;
	logic         rst = 1;
	logic         reg_wr = 0, reg_rd = 0;
	logic [15:0]  reg_addr = 0, reg_wdata = 0, reg_rdata_q, bus_addr_q, bus_wdata_q, bus_rdata;
	logic         bus_wr_q, bus_rd_q, bus_byte_q, irq_q;
	logic [127:0] trig_in = 0;
	int           bad_count = 0, compares = 0, nirq = 0;
	logic [31:0]  wq[$];
	logic [47:0]  rows[8] = '{{16'h04D0, 16'h1234, 16'h1234}, {16'h04D2, 16'hABCD, 16'hABCD},
		{16'h04D4, 16'h00FF, 16'h00FF}, {16'h04CE, 16'hFFFF, 16'h7FF9},
		{16'h04CE, 16'h0000, 16'h0000}, {16'h04CC, 16'hF6FE, 16'h06FE},
		{16'h04D6, 16'h5555, 16'h0000}, {16'h04CC, 16'h0000, 16'h0000}};
	always #12.5 core_clk = ~core_clk;
	dmaz_channel u_dmaz_channel (.*);
	dmaz_mem u_dmaz_mem (.*);
	always @(posedge core_clk) begin
		if (bus_wr_q === 1'b1)
			wq.push_back({bus_addr_q, bus_wdata_q});
		if (irq_q === 1'b1)
			nirq++;
	end
	function automatic [15:0] mv(input [15:0] a);
		mv = {a[7:0], ~a[15:8]};
	endfunction
	task chk(input string n, input [31:0] e, input [31:0] s);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input [15:0] a, input [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task rd(input [15:0] a, input [15:0] e, input [15:0] m);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 chk($sformatf("reg %h", a), e, reg_rdata_q & m);
	endtask
	task run(input [15:0] s, input [15:0] d, input [15:0] c, input [15:0] i, input [15:0] ctl);
		wr(`DMAZ_IDX_SRC, s);
		wr(`DMAZ_IDX_DST, d);
		wr(`DMAZ_IDX_CNT, c);
		wr(`DMAZ_IDX_IRQ, i);
		wq.delete();
		nirq = 0;
		wr(`DMAZ_IDX_CTRL, ctl);
		repeat (40) @(posedge core_clk);
	endtask
	task pulse(input int n);
		@(posedge core_clk);
		trig_in[n] <= 1;
		repeat (3) @(posedge core_clk);
		trig_in[n] <= 0;
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		results;
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 0;
		for (int k = 0; k < 5; k++)
			rd(16'h04CC + 2 * k, 16'h0000, 16'hFFFF);
		rd(`DMAZ_IDX_HIGH, 16'hFFFF, 16'hFFFF);
		$display("test reset done");
		foreach (rows[k]) begin
			wr(rows[k][47:32], rows[k][31:16]);
			rd(rows[k][47:32], rows[k][15:0], 16'hFFFF);
		end
		chk("sw irq", 0, nirq);
		$display("test registers done");
		run(16'h0900, 16'h0A00, 16'h0001, 16'h0000, 16'h0151);
		chk("word write", {16'h0A00, mv(16'h0900)}, wq[0]);
		rd(`DMAZ_IDX_CTRL, 16'h0050, 16'hFFFF);
		rd(`DMAZ_IDX_IRQ, 16'h0020, 16'hFFFF);
		rd(`DMAZ_IDX_SRC, 16'h0902, 16'hFFFF);
		rd(`DMAZ_IDX_CNT, 16'h0000, 16'hFFFF);
		run(16'h0905, 16'h0A10, 16'h0001, 16'h0000, 16'h0593);
		chk("byte write", {16'h0A10, mv(16'h0905) & 16'h00FF}, wq[0]);
		chk("dummy addr", 16'h0905, wq[1][31:16]);
		rd(`DMAZ_IDX_SRC, 16'h0904, 16'hFFFF);
		rd(`DMAZ_IDX_DST, 16'h0A11, 16'hFFFF);
		$display("test single done");
		for (int m = 0; m < 4; m++) begin
			run(16'h0900, 16'h0A00, 16'h0004, m & 1, 16'h0151 | (m << 2));
			chk("transfers", m[1] ? 4 : 1, wq.size());
			chk("irqs", m[1] ? 1 + m[0] : 0, nirq);
			rd(`DMAZ_IDX_CNT, m[1] ? (m[0] ? 4 : 0) : 3, 16'hFFFF);
		end
		$display("test modes done");
		run(16'h0900, 16'h0A00, 16'h0001, 16'h0500, 16'h0150);
		chk("off", 0, wq.size());
		wr(`DMAZ_IDX_CTRL, 16'h0051);
		pulse(6);
		repeat (10) @(posedge core_clk);
		chk("other trig", 0, wq.size());
		pulse(5);
		repeat (10) @(posedge core_clk);
		chk("own trig", 1, wq.size());
		run(16'h0900, 16'h0A00, 16'h0008, 16'h0500, 16'h0059);
		pulse(5);
		pulse(5);
		repeat (40) @(posedge core_clk);
		rd(`DMAZ_IDX_IRQ, 16'h0538, 16'hFFFF);
		$display("test triggers done");
		wr(`DMAZ_IDX_HIGH, 16'h0A00);
		run(16'h0900, 16'h0B00, 16'h0001, 16'h0000, 16'h0151);
		chk("late check", 16'h0B00, wq[0][31:16]);
		rd(`DMAZ_IDX_IRQ, 16'h0080, 16'h0080);
		wr(`DMAZ_IDX_HIGH, 16'hFFFF);
		wr(`DMAZ_IDX_LOW, 16'h0900);
		run(16'h0850, 16'h0A00, 16'h0001, 16'h0000, 16'h0151);
		rd(`DMAZ_IDX_IRQ, 16'h0040, 16'h0040);
		$display("test limits done");
		results;
	end
endmodule // dma_channel_zero_core_test
